// ### src/aux_i2c_master.sv
// auxiliary i2c master: register-addressed single or burst reads
// assumes sda_in already synchronised to mclk; no clock stretching
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

module aux_i2c_master (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic go,
	input wire logic [6:0] dev,
	input wire logic [7:0] regaddr,
	input wire logic [3:0] len,
	input wire logic sda_in,
	output logic scl_oe,
	output logic sda_oe,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic busy,
	output logic nack_err
);
	import host_port_pkg::*;

	localparam int MST_START_MAX = 400; // bound for start condition
	mst_st_t st; // sequencer state
	mstep_t step; // transaction step
	logic [1:0] phase; // quarter of a bit
	logic [3:0] bitn; // bit within a byte, 8 is ack
	logic [7:0] sr; // shift register
	logic [3:0] left; // bytes still to read
	logic rd; // current byte is a read
	logic [7:0] qtr; // quarter period counter
	logic tick; // quarter period elapsed

	// ****************************************
	// quarter-period timebase
	// ****************************************
	assign tick = (qtr == 8'(`MST_QTR_CYC - 1));

	// counter restarts whenever idle
	always_ff @(posedge mclk)
	begin
		if (sys_rst || st == M_IDLE || tick)
			qtr <= '0;
		else
			qtr <= qtr + 8'h01;
	end

	// ****************************************
	// bus sequencer
	// ****************************************
	// disabled master lets go of both lines at once
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !enable)
		begin
			st <= M_IDLE;
			step <= S_ADDR_W;
			phase <= '0;
			bitn <= '0;
			sr <= '0;
			left <= '0;
			rd <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			rdata <= '0;
			rvalid <= 1'b0;
			busy <= 1'b0;
			nack_err <= 1'b0;
		end
		else
		begin
			rvalid <= 1'b0;
			case (st)
				M_IDLE:
					if (go)
					begin
						st <= M_START;
						step <= S_ADDR_W;
						phase <= '0;
						left <= (len == 4'h0) ? 4'h1 : len;
						busy <= 1'b1;
						nack_err <= 1'b0;
					end
				M_START: // start or repeated start
					if (tick)
					begin
						phase <= phase + 2'h1;
						case (phase)
							2'h0: sda_oe <= 1'b0;
							2'h1: scl_oe <= 1'b0;
							2'h2: sda_oe <= 1'b1;
							default:
							begin
								scl_oe <= 1'b1;
								st <= M_BYTE;
								bitn <= '0;
								rd <= 1'b0;
								sr <= {dev, (step == S_ADDR_R)};
							end
						endcase
					end
				M_BYTE:
					if (tick)
					begin
						phase <= phase + 2'h1;
						case (phase)
							2'h0: // ack all read bytes but the last
								if (bitn == `ACK_SLOT)
									sda_oe <= rd && (left != 4'h1);
								else
									sda_oe <= !rd && !sr[7];
							2'h1: scl_oe <= 1'b0;
							2'h2: // sample while clock high
								if (bitn != `ACK_SLOT)
									sr <= {sr[6:0], sda_in};
								else if (!rd && sda_in)
									nack_err <= 1'b1;
							default:
							begin
								scl_oe <= 1'b1;
								if (bitn != `ACK_SLOT)
									bitn <= bitn + 4'h1;
								else
								begin
									bitn <= '0;
									if (nack_err)
										st <= M_STOP;
									else if (rd)
									begin
										rdata <= sr;
										rvalid <= 1'b1;
										left <= left - 4'h1;
										if (left == 4'h1)
											st <= M_STOP;
									end
									else
										case (step)
											S_ADDR_W:
											begin
												step <= S_REG;
												sr <= regaddr;
											end
											S_REG:
											begin
												step <= S_ADDR_R;
												st <= M_START;
											end
											default:
											begin
												step <= S_DATA;
												rd <= 1'b1;
											end
										endcase
								end
							end
						endcase
					end
				M_STOP:
					if (tick)
					begin
						phase <= phase + 2'h1;
						case (phase)
							2'h0: sda_oe <= 1'b1;
							2'h1: scl_oe <= 1'b0;
							2'h2: sda_oe <= 1'b0;
							default:
							begin
								st <= M_IDLE;
								busy <= 1'b0;
							end
						endcase
					end
				default: st <= M_IDLE;
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence seq_go;
		go && enable && st == M_IDLE;
	endsequence
	sequence seq_start_cond;
		sda_oe && !scl_oe;
	endsequence
	AST_MST_START: assert property (seq_go |-> ##[1:MST_START_MAX] seq_start_cond)
		else $error("aux master did not issue a start");
	AST_MST_LAST_NACK: assert property ((st == M_BYTE && rd && bitn == `ACK_SLOT
		&& left == 4'h1 && phase == 2'h1) |-> !sda_oe)
		else $error("last read byte was acknowledged");
endmodule : aux_i2c_master
`default_nettype wire

// ### src/host_port_aux_i2c_bypass.sv
// host slave port (i2c or spi) with auxiliary sensor bus routing
// assumes open-drain pads outside, memory and fifo readers on mclk
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defines.svh"

// Operation
// - device is only ever slave to host
// - host programs device and reads memories
// - i2c standard, fast, fast-plus speed classes
// - i2c high-speed class up to limit
// - spi serial clock up to limit
// - spi uses four shared pins
// - bypass joins host lines to sensor bus
// - bypass off before aux master takes bus
// - no bypass while host uses spi
// - aux master issues sensor transactions while bypass is off
// - pass-through links host and sensors directly
// - aux master does single and burst reads
// - host can write and read the fifo
// - aux master disabled during pass-through
module host_port_aux_i2c_bypass (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic host_spi_sel,
	input wire logic bypass_en,
	input wire logic host_clk_in,
	input wire logic host_dat_in,
	output logic host_dat_out,
	output logic host_dat_oe,
	input wire logic host_sel_n_in,
	input wire logic host_sdo_in,
	output logic host_sdo_out,
	output logic host_sdo_oe,
	input wire logic sensor_bus_clock_pin_in,
	output logic sensor_bus_clock_pin_out,
	output logic sensor_bus_clock_pin_oe,
	input wire logic sensor_bus_data_pin_in,
	output logic sensor_bus_data_pin_out,
	output logic sensor_bus_data_pin_oe,
	output logic [6:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] fifo_wdata,
	output logic fifo_push,
	output logic fifo_pop,
	input wire logic [7:0] fifo_rdata,
	input wire logic aux_go,
	input wire logic [6:0] aux_dev,
	input wire logic [7:0] aux_reg,
	input wire logic [3:0] aux_len,
	output logic [7:0] aux_rdata,
	output logic aux_rvalid,
	output logic aux_busy,
	output logic aux_nack
);
	import host_port_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [5:0] pin_meta; // first stage
	logic [5:0] pin_sync; // second stage
	logic [5:0] pin_prev; // for edge detection
	logic hclk, hdat, sel_n, ad0, sdat; // synced levels
	logic hclk_rise, hclk_fall, hdat_rise, hdat_fall;

	// two flops per pin, then one more for edges
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pin_meta <= `PIN_IDLE;
			pin_sync <= `PIN_IDLE;
			pin_prev <= `PIN_IDLE;
		end
		else
		begin
			pin_meta <= {sensor_bus_data_pin_in, sensor_bus_clock_pin_in, host_sdo_in,
				host_sel_n_in, host_dat_in, host_clk_in};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// sampling at mclk keeps up with every host speed class
	assign hclk = pin_sync[`PIN_HCLK];
	assign hdat = pin_sync[`PIN_HDAT];
	assign sel_n = pin_sync[`PIN_SEL];
	assign ad0 = pin_sync[`PIN_AD0];
	assign sdat = pin_sync[`PIN_SDAT];
	assign hclk_rise = hclk && !pin_prev[`PIN_HCLK];
	assign hclk_fall = !hclk && pin_prev[`PIN_HCLK];
	assign hdat_rise = hdat && !pin_prev[`PIN_HDAT];
	assign hdat_fall = !hdat && pin_prev[`PIN_HDAT];

	// ****************************************
	// mode and bypass control
	// ****************************************
	logic spi_mode; // host link is spi
	logic pass; // pass-through active

	// bypass comes up off; spi mode forbids it
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			spi_mode <= 1'b0;
			pass <= 1'b0;
		end
		else
		begin
			spi_mode <= host_spi_sel;
			pass <= bypass_en && !host_spi_sel;
		end
	end

	// ****************************************
	// host serial engine
	// ****************************************
	host_st_t st; // i2c slave state
	logic [3:0] cnt; // bit counter
	logic [7:0] sr; // receive shift register
	logic [7:0] tx; // transmit byte
	logic nack; // host answer to a read byte
	logic dat_oe; // slave pulls data low
	logic sdo; // spi output bit
	logic rx_stb; // one byte received
	logic take_stb; // one read byte consumed
	logic first; // next byte is the pointer
	logic spi_rd; // spi transfer is a read
	logic [6:0] ptr; // memory pointer
	logic [7:0] rd_byte; // byte offered to the host

	// fifo sits behind one pointer value
	assign rd_byte = (ptr == `FIFO_PTR) ? fifo_rdata : mem_rdata;

	// pointer steps except at the fifo
	function automatic logic [6:0] next_ptr(input logic [6:0] p);
		next_ptr = (p == `FIFO_PTR) ? p : p + 7'h01;
	endfunction : next_ptr

	// slave only: answers on edges the host makes
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st <= H_IDLE;
			cnt <= '0;
			sr <= '0;
			tx <= '0;
			nack <= 1'b0;
			dat_oe <= 1'b0;
			sdo <= 1'b0;
			rx_stb <= 1'b0;
			take_stb <= 1'b0;
			first <= 1'b1;
		end
		else
		begin
			rx_stb <= 1'b0;
			take_stb <= 1'b0;
			if (rx_stb)
				first <= 1'b0;
			if (spi_mode)
			begin
				dat_oe <= 1'b0;
				st <= H_IDLE;
				if (sel_n) // deselected: frame restarts
				begin
					cnt <= '0;
					first <= 1'b1;
				end
				else
				begin
					if (hclk_rise) // sample input on rising clock
					begin
						sr <= {sr[6:0], hdat};
						cnt <= (cnt == `BIT_LAST) ? 4'h0 : cnt + 4'h1;
						rx_stb <= (cnt == `BIT_LAST);
					end
					if (hclk_fall && spi_rd)
					begin
						if (cnt == 4'h0)
						begin
							tx <= rd_byte;
							sdo <= rd_byte[7];
							take_stb <= 1'b1;
						end
						else
							sdo <= tx[3'(`BIT_LAST - cnt)];
					end
				end
			end
			else if (hclk && pin_prev[`PIN_HCLK] && hdat_fall) // start
			begin
				st <= H_ADDR;
				cnt <= '0;
				dat_oe <= 1'b0;
				first <= 1'b1;
			end
			else if (hclk && pin_prev[`PIN_HCLK] && hdat_rise) // stop
			begin
				st <= H_IDLE;
				dat_oe <= 1'b0;
			end
			else if (st != H_IDLE)
			begin
				if (hclk_rise)
				begin
					if (cnt < `ACK_SLOT)
						sr <= {sr[6:0], hdat};
					else
						nack <= hdat;
					cnt <= cnt + 4'h1;
				end
				if (hclk_fall)
				begin
					if (cnt == `ACK_SLOT) // ack slot opens
						case (st)
							H_ADDR:
								if (sr[7:1] == {`I2C_ADDR_HI, ad0})
								begin
									dat_oe <= 1'b1;
									st <= sr[0] ? H_RD : H_WR;
								end
								else
									st <= H_IDLE;
							H_WR:
							begin
								dat_oe <= 1'b1;
								rx_stb <= 1'b1;
							end
							default: dat_oe <= 1'b0;
						endcase
					else if (cnt == `ACK_END) // ack slot closes
					begin
						cnt <= '0;
						if (st == H_RD && !nack)
						begin
							tx <= rd_byte;
							dat_oe <= !rd_byte[7];
							take_stb <= 1'b1;
						end
						else
						begin
							dat_oe <= 1'b0;
							if (st == H_RD)
								st <= H_IDLE;
						end
					end
					else if (st == H_RD)
						dat_oe <= !tx[3'(`BIT_LAST - cnt)];
				end
			end
		end
	end

	// ****************************************
	// memory and fifo access
	// ****************************************
	logic bump; // step pointer after a write

	// first byte loads pointer, later ones write unless the frame is an spi read
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ptr <= `PTR_RST;
			spi_rd <= 1'b0;
			bump <= 1'b0;
			mem_we <= 1'b0;
			fifo_push <= 1'b0;
			fifo_pop <= 1'b0;
			mem_wdata <= '0;
			fifo_wdata <= '0;
		end
		else
		begin
			mem_we <= 1'b0;
			fifo_push <= 1'b0;
			fifo_pop <= 1'b0;
			bump <= 1'b0;
			if (spi_mode && sel_n)
				spi_rd <= 1'b0;
			if (bump)
				ptr <= next_ptr(ptr);
			else if (rx_stb && first)
			begin
				ptr <= sr[6:0];
				spi_rd <= spi_mode && sr[`SPI_RD_BIT];
			end
			else if (rx_stb && !spi_rd)
			begin
				fifo_push <= (ptr == `FIFO_PTR);
				mem_we <= (ptr != `FIFO_PTR);
				fifo_wdata <= sr;
				mem_wdata <= sr;
				bump <= 1'b1;
			end
			else if (take_stb)
			begin
				fifo_pop <= (ptr == `FIFO_PTR);
				ptr <= next_ptr(ptr);
			end
		end
	end

	assign mem_addr = ptr;

	// ****************************************
	// auxiliary master
	// ****************************************
	logic m_scl_oe, m_sda_oe; // master line drives

	// master runs only while bypass is off
	aux_i2c_master u_aux_master (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.enable(!pass),
		.go(aux_go),
		.dev(aux_dev),
		.regaddr(aux_reg),
		.len(aux_len),
		.sda_in(sdat),
		.scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe),
		.rdata(aux_rdata),
		.rvalid(aux_rvalid),
		.busy(aux_busy),
		.nack_err(aux_nack)
	);

	// ****************************************
	// pass-through data ownership
	// ****************************************
	own_t owner; // side pulling data low
	logic [1:0] hold; // quiet time after release

	// first side low owns; echoes are ignored
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !pass)
		begin
			owner <= OWN_NONE;
			hold <= '0;
		end
		else if (hold != 2'h0)
			hold <= hold - 2'h1;
		else
			case (owner)
				OWN_NONE:
					if (!hdat && !dat_oe)
						owner <= OWN_HOST;
					else if (!sdat)
						owner <= OWN_SENS;
				OWN_HOST:
					if (hdat)
					begin
						owner <= OWN_NONE;
						hold <= `PASS_HOLD;
					end
				OWN_SENS:
					if (sdat)
					begin
						owner <= OWN_NONE;
						hold <= `PASS_HOLD;
					end
				default: owner <= OWN_NONE;
			endcase
	end

	// ****************************************
	// pin drivers
	// ****************************************
	// bypass mirrors host lines, else master owns
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sensor_bus_clock_pin_oe <= 1'b0;
			sensor_bus_data_pin_oe <= 1'b0;
			host_dat_oe <= 1'b0;
			host_sdo_oe <= 1'b0;
			host_sdo_out <= 1'b0;
		end
		else
		begin
			sensor_bus_clock_pin_oe <= pass ? !hclk : m_scl_oe;
			sensor_bus_data_pin_oe <= pass ? (owner == OWN_HOST) : m_sda_oe;
			host_dat_oe <= dat_oe || (pass && owner == OWN_SENS);
			host_sdo_oe <= spi_mode && !sel_n;
			host_sdo_out <= sdo;
		end
	end

	// open-drain lines only ever pull low
	always_ff @(posedge mclk)
	begin
		host_dat_out <= 1'b0;
		sensor_bus_clock_pin_out <= 1'b0;
		sensor_bus_data_pin_out <= 1'b0;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_SLAVE_ONLY: assert property ((!pass && ((spi_mode && $past(spi_mode))
		|| (!spi_mode && st == H_IDLE))) |=> !host_dat_oe)
		else $error("host data driven outside a slave answer");
	AST_SPI_SDO: assert property (spi_mode |=> host_sdo_oe == !$past(sel_n))
		else $error("spi output enable does not follow select");
	AST_NO_PASS_SPI: assert property (pass |-> !spi_mode)
		else $error("bypass active in spi mode");
	AST_PASS_CLK: assert property (pass |=> sensor_bus_clock_pin_oe == !$past(hclk))
		else $error("sensor clock does not follow host clock");
	AST_PASS_MST_OFF: assert property (pass |=> !m_scl_oe && !m_sda_oe)
		else $error("aux master drives during pass-through");
	AST_WR_MEM: assert property ((rx_stb && !first && !bump && !spi_rd
		&& ptr != `FIFO_PTR) |=> mem_we && mem_addr == $past(ptr) && mem_wdata == $past(sr)
		##1 !mem_we)
		else $error("host write did not reach memory");
	AST_FIFO_PUSH: assert property ((rx_stb && !first && !bump && !spi_rd
		&& ptr == `FIFO_PTR) |=> fifo_push ##1 !fifo_push)
		else $error("host write did not push the fifo");
	AST_BYPASS_RST: assert property (@(posedge mclk) disable iff (1'b0)
		sys_rst |=> !pass)
		else $error("bypass not off after reset");
endmodule : host_port_aux_i2c_bypass
`default_nettype wire

// ### src/host_port_defines.svh
// constants for the host serial port and auxiliary sensor bus block
// assumes an mclk of 125 MHz; included by the design files
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// system clock period
`define MCLK_PERIOD_NS 8
// host link speed classes, in kHz
`define I2C_STD_KHZ 80
`define I2C_FAST_KHZ 320
`define I2C_FPLUS_KHZ 800
`define I2C_HS_KHZ 2700
`define SPI_MAX_KHZ 6400
// shortest host clock half period, in mclk cycles
`define HOST_MIN_HALF_CYC ((500000 / `SPI_MAX_KHZ) / `MCLK_PERIOD_NS)
// synchroniser bit positions and idle level
`define PIN_IDLE 6'h3F
`define PIN_HCLK 0
`define PIN_HDAT 1
`define PIN_SEL 2
`define PIN_AD0 3
`define PIN_SCLK 4
`define PIN_SDAT 5
// upper six bits of the host slave address, lsb from the address strap
`define I2C_ADDR_HI 6'h34
// pointer value that reaches the fifo, pointer reset value
`define FIFO_PTR 7'h7F
`define PTR_RST 7'h00
// bit counter landmarks
`define BIT_LAST 4'h7
`define ACK_SLOT 4'h8
`define ACK_END 4'h9
// read flag in the first spi byte
`define SPI_RD_BIT 7
// quiet cycles after a pass-through data owner lets go
`define PASS_HOLD 2'h3
// auxiliary master clock period and quarter-period count
`define MST_SCL_PERIOD_NS 2500
`define MST_QTR_CYC ((`MST_SCL_PERIOD_NS / 4) / `MCLK_PERIOD_NS)

`endif

// ### src/host_port_pkg.sv
// types shared by the host port and the auxiliary master
// assumes host_port_defines.svh is on the include path
package host_port_pkg;
	// host engine states
	typedef enum logic [1:0] {H_IDLE, H_ADDR, H_WR, H_RD} host_st_t;
	// pass-through data line owner
	typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_SENS} own_t;
	// auxiliary master states
	typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} mst_st_t;
	// auxiliary master transaction step
	typedef enum logic [1:0] {S_ADDR_W, S_REG, S_ADDR_R, S_DATA} mstep_t;
endpackage : host_port_pkg

// ### tb/host_master_model.sv
// host processor model: i2c or spi master on the shared host pins
// assumes the bench resolves the open-drain data wire; pins move on mclk falls
`timescale 1ns/10ps
`default_nettype none

module host_master_model (
	input wire logic mclk,
	input wire logic sda_wire,
	input wire logic sdo,
	output logic scl,
	output logic sda_low,
	output logic sel_n
);
	int half = 25; // mclk cycles per host clock half, set by the bench
	logic [7:0] rx; // bits seen on the data wire in the last byte
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		sel_n = 1'b1;
	end
	// wait n falling edges, so no pin moves on a sampling edge
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick
	// start: data falls while the clock is high; only the host opens a frame
	task automatic i2c_start;
		sda_low = 1'b1;
		tick(half);
		scl = 1'b0;
	endtask : i2c_start
	task automatic i2c_stop;
		tick(2);
		sda_low = 1'b1;
		tick(half);
		scl = 1'b1;
		tick(half);
		sda_low = 1'b0;
		tick(half);
	endtask : i2c_stop
	// eight bits msb first, ninth clock reads the acknowledge
	task automatic i2c_byte(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--)
		begin
			tick(2);
			sda_low = (i > 0) ? ~b[i-1] : 1'b0;
			tick(half - 2);
			scl = 1'b1;
			tick(half);
			if (i == 0)
				ack = sda_wire;
			else
				rx[i-1] = sda_wire;
			scl = 1'b0;
		end
	endtask : i2c_byte
	// spi frame: clock idles low, select low for the whole frame
	task automatic spi_begin;
		scl = 1'b0;
		sel_n = 1'b0;
		tick(half);
	endtask : spi_begin
	task automatic spi_end;
		tick(half);
		sel_n = 1'b1;
		tick(half);
	endtask : spi_end
	// mode 0: data set while clock low, both sides sample on the rise
	task automatic spi_byte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
		begin
			sda_low = ~b[i];
			tick(half);
			scl = 1'b1;
			r[i] = sdo;
			tick(half);
			scl = 1'b0;
		end
	endtask : spi_byte
endmodule : host_master_model

`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the host port with auxiliary bus routing
// assumes the design package and defines header are compiled first
`timescale 1ns/10ps
`default_nettype none

module tb;
	import host_port_pkg::*;
	logic mclk, sys_rst, host_spi_sel, bypass_en, sens_low, aux_go;
	logic [6:0] aux_dev;
	logic [7:0] aux_reg, fifo_rdata;
	logic [3:0] aux_len;
	logic [7:0] img [128]; // memory behind the port, random contents
	logic h_scl, h_sda_low, h_sel_n, host_dat_oe, host_sdo_out, host_sdo_oe;
	logic sensor_bus_clock_pin_oe, sensor_bus_data_pin_oe, mem_we, fifo_push;
	logic [6:0] mem_addr;
	logic [7:0] mem_wdata, fifo_wdata, aux_rdata;
	logic aux_rvalid, aux_busy, aux_nack;
	logic host_dat_out, aux_scl_out, aux_sda_out, fifo_pop, ad0_strap;
	int n_pop = 0; // fifo pops seen
	logic [14:0] exp_mem [$]; // expected memory writes {addr, data}
	logic [7:0] exp_fifo [$];
	int n_fail = 0;
	int check_count = 0;
	// open-drain wires: a driven pad shows its out value, else the pull-up
	wire host_sda = ~h_sda_low & (host_dat_oe ? host_dat_out : 1'b1);
	wire aux_scl = sensor_bus_clock_pin_oe ? aux_scl_out : 1'b1;
	wire aux_sda = ~sens_low & (sensor_bus_data_pin_oe ? aux_sda_out : 1'b1);
	// released sdo shows a moving value
	wire sdo_w = host_sdo_oe ? host_sdo_out : ~host_sdo_out;

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	host_master_model host (.mclk(mclk), .sda_wire(host_sda), .sdo(sdo_w), .scl(h_scl),
		.sda_low(h_sda_low), .sel_n(h_sel_n));

	host_port_aux_i2c_bypass dut (.mclk(mclk), .sys_rst(sys_rst), .host_spi_sel(host_spi_sel),
		.bypass_en(bypass_en), .host_clk_in(h_scl), .host_dat_in(host_sda),
		.host_dat_out(host_dat_out), .host_dat_oe(host_dat_oe), .host_sel_n_in(h_sel_n),
		.host_sdo_in(ad0_strap), .host_sdo_out(host_sdo_out), .host_sdo_oe(host_sdo_oe),
		.sensor_bus_clock_pin_in(aux_scl), .sensor_bus_clock_pin_out(aux_scl_out),
		.sensor_bus_clock_pin_oe(sensor_bus_clock_pin_oe), .sensor_bus_data_pin_in(aux_sda),
		.sensor_bus_data_pin_out(aux_sda_out),
		.sensor_bus_data_pin_oe(sensor_bus_data_pin_oe),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(img[mem_addr]),
		.fifo_wdata(fifo_wdata), .fifo_push(fifo_push), .fifo_pop(fifo_pop),
		.fifo_rdata(fifo_rdata),
		.aux_go(aux_go), .aux_dev(aux_dev), .aux_reg(aux_reg), .aux_len(aux_len),
		.aux_rdata(aux_rdata), .aux_rvalid(aux_rvalid), .aux_busy(aux_busy), .aux_nack(aux_nack));

	// ************************************************************
	// compare, verdict
	// ************************************************************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// every write the design makes must be the next one expected
	always @(posedge mclk)
	begin
		if (mem_we === 1'b1)
			check("mem write", exp_mem.size() > 0 ? {1'b0, exp_mem.pop_front()} : 16'hFFFF,
				{1'b0, mem_addr, mem_wdata});
		if (fifo_push === 1'b1)
			check("fifo push", exp_fifo.size() > 0 ? {8'h00, exp_fifo.pop_front()} : 16'hFFFF,
				{8'h00, fifo_wdata});
		if (fifo_pop === 1'b1)
			n_pop++;
	end

	// ************************************************************
	// host transfers
	// ************************************************************
	// address, pointer, two data bytes; a foreign address is never acked
	task automatic i2c_wr(input int h, input logic [7:0] adr, input logic [7:0] p,
		input logic [7:0] d);
		logic a;
		logic nack;
		nack = (adr != {6'h34, ad0_strap, 1'b0});
		if (!nack && p == 8'h7F)
		begin
			exp_fifo.push_back(d);
			exp_fifo.push_back(d + 8'h01);
		end
		else if (!nack)
		begin
			exp_mem.push_back({p[6:0], d});
			exp_mem.push_back({p[6:0] + 7'h01, d + 8'h01});
		end
		host.half = h;
		host.i2c_start();
		host.i2c_byte(adr, a);
		check("address ack", {15'h0, nack}, {15'h0, a});
		host.i2c_byte(p, a);
		check("pointer ack", {15'h0, nack}, {15'h0, a});
		host.i2c_byte(d, a);
		host.i2c_byte(d + 8'h01, a);
		check("data ack", {15'h0, nack}, {15'h0, a});
		host.i2c_stop();
	endtask : i2c_wr
	// spi frame of three bytes; half of 10 cycles keeps sclk at 6.25 MHz
	task automatic spi_txn(input logic [7:0] f, input logic [7:0] d, output logic [7:0] r1,
		output logic [7:0] r2);
		logic [7:0] r0;
		host.half = 10;
		host.spi_begin();
		check("sdo drive", 16'h1, {15'h0, host_sdo_oe});
		host.spi_byte(f, r0);
		host.spi_byte(d, r1);
		host.spi_byte(d + 8'h01, r2);
		host.spi_end();
	endtask : spi_txn
	// one auxiliary read; the sensor model holding data low acks and reads zero
	task automatic aux_run(input logic [3:0] n, input int exp_n, input logic exp_nack);
		int seen;
		seen = 0;
		aux_len = n;
		aux_dev = 7'($urandom);
		aux_reg = 8'($urandom);
		aux_go = 1'b1;
		@(negedge mclk);
		aux_go = 1'b0;
		repeat (2) @(negedge mclk);
		check("aux busy", 16'h1, {15'h0, aux_busy});
		for (int k = 0; k < 40000 && aux_busy === 1'b1; k++)
		begin
			@(negedge mclk);
			if (aux_rvalid === 1'b1)
			begin
				seen++;
				check("aux data", 16'h0, {8'h00, aux_rdata});
			end
		end
		check("aux bytes", 16'(exp_n), 16'(seen));
		check("aux nack", {15'h0, exp_nack}, {15'h0, aux_nack});
		check("aux done", 16'h0, {15'h0, aux_busy});
	endtask : aux_run

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		logic [7:0] p, d, r1, r2;
		logic a;
		{sys_rst, host_spi_sel, bypass_en, sens_low, aux_go} = 5'b10000;
		{aux_dev, aux_reg, aux_len} = 19'h0;
		void'($urandom(25022));
		for (int i = 0; i < 128; i++)
			img[i] = 8'($urandom);
		fifo_rdata = 8'($urandom);
		ad0_strap = 1'($urandom);
		repeat (2) @(negedge mclk);
		sys_rst = 1'b0;
		@(negedge mclk);
		check("idle drives", 16'h0, {12'h0, host_dat_oe, host_sdo_oe, sensor_bus_clock_pin_oe,
			sensor_bus_data_pin_oe});
		repeat (4) @(negedge mclk);
		p = 8'($urandom_range(0, 125));
		d = 8'($urandom);
		i2c_wr(25, {6'h34, ad0_strap, 1'b0}, p, d);
		i2c_wr(79, {6'h34, ad0_strap, 1'b0}, 8'h7F, ~d);
		i2c_wr(25, 8'hA0, p, d);
		// pointer still rests on the fifo after the fifo writes
		host.i2c_start();
		host.i2c_byte({6'h34, ad0_strap, 1'b1}, a);
		check("read address ack", 16'h0, {15'h0, a});
		host.i2c_byte(8'hFF, a);
		host.i2c_stop();
		check("fifo read", {8'h00, fifo_rdata}, {8'h00, host.rx});
		check("fifo pop", 16'h1, 16'(n_pop));
		host_spi_sel = 1'b1;
		exp_mem.push_back({p[6:0], d});
		exp_mem.push_back({p[6:0] + 7'h01, d + 8'h01});
		spi_txn({1'b0, p[6:0]}, d, r1, r2);
		p = 8'($urandom_range(0, 125));
		spi_txn({1'b1, p[6:0]}, 8'h00, r1, r2);
		check("spi read", {img[p[6:0]], img[p[6:0] + 7'h01]}, {r1, r2});
		check("idle drives", 16'h0, {15'h0, host_sdo_oe});
		check("write queue", 16'h0, 16'(exp_mem.size() + exp_fifo.size()));
		bypass_en = 1'b1;
		host.tick(8);
		check("aux clock in spi", 16'h0, {15'h0, sensor_bus_clock_pin_oe});
		host_spi_sel = 1'b0;
		host.scl = 1'b1;
		host.tick(8);
		check("aux clock high", 16'h0, {15'h0, sensor_bus_clock_pin_oe});
		host.scl = 1'b0;
		host.tick(8);
		check("aux clock low", 16'h1, {15'h0, sensor_bus_clock_pin_oe});
		host.sda_low = 1'b1;
		host.tick(8);
		check("aux data low", 16'h1, {15'h0, sensor_bus_data_pin_oe});
		host.sda_low = 1'b0;
		host.tick(8);
		sens_low = 1'b1;
		host.tick(8);
		check("host data low", 16'h1, {15'h0, host_dat_oe});
		sens_low = 1'b0;
		host.scl = 1'b1;
		host.tick(8);
		aux_go = 1'b1;
		host.tick(1);
		aux_go = 1'b0;
		host.tick(400);
		check("master in pass", 16'h0, {15'h0, aux_busy, sensor_bus_clock_pin_oe});
		bypass_en = 1'b0;
		host.tick(8);
		sens_low = 1'b1;
		aux_run(4'h1, 1, 1'b0);
		aux_run(4'h3, 3, 1'b0);
		sens_low = 1'b0;
		aux_run(4'h1, 0, 1'b1);
		conclude();
	end

	// watchdog, well beyond the roughly 370 us the sequence needs
	initial
	begin
		#700000;
		n_fail++;
		conclude();
	end
endmodule : tb

`default_nettype wire
